// file: ccp_top.sv
// Capture/compare/PWM unit with APB register slave
`timescale 1ns/1ps
`default_nettype none
module ccp_top
(
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [11:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic [31:0]             prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // Timer and converter side
   input  wire ccp_pkg::timebase_t tb_i,
   output logic                    timer1_reset_o,
   output logic                    adc_start_o,
   // Port pin zero
   input  wire logic               port_pin_zero_i,
   output logic                    port_pin_zero_o,
   output logic                    port_pin_zero_oe_o,
   // Port pin three
   input  wire logic               port_pin_three_i,
   output logic                    port_pin_three_o,
   output logic                    port_pin_three_oe_o,
   // Interrupt
   output logic                    irq_o
);
   // ************************************************************************
   // Registers
   // ************************************************************************
   logic [7:0]  ctrl_ff;
   logic [15:0] value_ff;        // unit_value_register
   logic [15:0] config_ff;
   logic [2:0]  status_ff;
   logic [2:0]  mask_ff;
   logic        pin_out_ff;
   logic        cmp_hit_ff;
   logic        cmp_ev_ff;

   // Decode of the APB access phase; a write lands only on the edge that completes it
   wire        wr_en   = psel_i & penable_i & pwrite_i & pready_o;
   wire        rd_en   = psel_i & penable_i & ~pwrite_i;
   wire        sel_ctl = (paddr_i == ccp_pkg::ADDR_CTRL);
   wire        sel_lo  = (paddr_i == ccp_pkg::ADDR_VAL_LO);
   wire        sel_hi  = (paddr_i == ccp_pkg::ADDR_VAL_HI);
   wire        sel_st  = (paddr_i == ccp_pkg::ADDR_STATUS);
   wire        sel_msk = (paddr_i == ccp_pkg::ADDR_MASK);
   wire        sel_cfg = (paddr_i == ccp_pkg::ADDR_CONFIG);
   wire        mapped  = sel_ctl | sel_lo | sel_hi | sel_st | sel_msk | sel_cfg;

   // Mode decode
   wire [3:0]  unit_mode_select = ctrl_ff[ccp_pkg::MODE_LSB +: 4];
   wire        mode_off = (unit_mode_select == ccp_pkg::MODE_OFF);
   wire        mode_pwm = (unit_mode_select[3:2] == 2'b11);
   wire        mode_cmp = (unit_mode_select[3:2] == 2'b10);
   wire        pin_route_select = config_ff[ccp_pkg::ROUTE_BIT];
   wire        unit_io_pin_in = pin_route_select ? port_pin_zero_i : port_pin_three_i;
   wire [9:0]  duty = {value_ff[7:0], ctrl_ff[ccp_pkg::DUTY_X_POS],
                       ctrl_ff[ccp_pkg::DUTY_Y_POS]};

   // Compare against Timer1; only a fresh match raises an event
   wire        cmp_match = mode_cmp & (tb_i.timer1 == value_ff);
   wire        cmp_event = cmp_match & ~cmp_hit_ff;
   wire        special   = cmp_event & (unit_mode_select == ccp_pkg::MODE_CMP_SPC);

   // ************************************************************************
   // Sub-units
   // ************************************************************************
   wire capture_ev;
   wire pwm_level;
   wire pwm_period;
   ccp_capture_unit u_cap
   (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .mode_i    (unit_mode_select),
      .pin_i     (unit_io_pin_in),
      .capture_o (capture_ev)
   );
   ccp_pwm_unit u_pwm
   (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .enable_i  (mode_pwm),
      .duty_i    (duty),
      .timer2_i  (tb_i.timer2),
      .period_i  (tb_i.timer2_period),
      .pwm_o     (pwm_level),
      .period_o  (pwm_period)
   );

   // Events that raise status; set wins over a clear in the same cycle
   wire [2:0] ev_bits = {pwm_period, cmp_event, capture_ev};
   wire [2:0] clr_bits = (wr_en & sel_st) ? pwdata_i[2:0] : 3'b000;
   wire [2:0] nxt_status = (status_ff & ~clr_bits) | ev_bits;

   // Compare output level
   wire nxt_pin_out = mode_off ? 1'b0 :
                      (cmp_event && unit_mode_select == ccp_pkg::MODE_CMP_SET) ? 1'b1 :
                      (cmp_event && unit_mode_select == ccp_pkg::MODE_CMP_CLR) ? 1'b0 :
                      pin_out_ff;
   wire unit_io_pin_out = mode_pwm ? pwm_level : pin_out_ff;
   wire drive = mode_cmp | mode_pwm;

   // Read mux
   wire [31:0] rd_mux = sel_ctl ? {24'h000000, ctrl_ff & 8'h3F} :
                        sel_lo  ? {24'h000000, value_ff[7:0]} :
                        sel_hi  ? {24'h000000, value_ff[15:8]} :
                        sel_st  ? {29'h00000000, status_ff} :
                        sel_msk ? {29'h00000000, mask_ff} :
                        sel_cfg ? {16'h0000, config_ff} : 32'h00000000;

   // ************************************************************************
   // Registers and outputs
   // ************************************************************************
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl_ff   <= ccp_pkg::CTRL_RST;
         value_ff  <= 16'h0000;
         config_ff <= ccp_pkg::CONFIG_RST;
         status_ff <= 3'h0;
         mask_ff   <= 3'h0;
         pin_out_ff <= 1'b0;
         cmp_hit_ff <= 1'b0;
         cmp_ev_ff  <= 1'b0;
      end
      else
      begin
         cmp_hit_ff <= cmp_match;
         cmp_ev_ff  <= cmp_event;
         pin_out_ff <= nxt_pin_out;
         status_ff  <= nxt_status;
         if (wr_en && sel_ctl)
            ctrl_ff <= pwdata_i[7:0] & 8'h3F;
         if (wr_en && sel_msk)
            mask_ff <= pwdata_i[2:0];
         if (wr_en && sel_cfg)
            config_ff <= pwdata_i[15:0];
         // Capture latches Timer1; byte writes reach each half
         if (capture_ev)
            value_ff <= tb_i.timer1;
         else if (wr_en && sel_lo)
            value_ff[7:0] <= pwdata_i[7:0];
         else if (wr_en && sel_hi)
            value_ff[15:8] <= pwdata_i[7:0];
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prdata_o            <= 32'h00000000;
         pready_o            <= 1'b0;
         pslverr_o           <= 1'b0;
         timer1_reset_o      <= 1'b0;
         adc_start_o         <= 1'b0;
         port_pin_zero_o     <= 1'b0;
         port_pin_zero_oe_o  <= 1'b0;
         port_pin_three_o    <= 1'b0;
         port_pin_three_oe_o <= 1'b0;
         irq_o               <= 1'b0;
      end
      else
      begin
         // One wait state: answer in the cycle after the access phase starts
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
         prdata_o  <= (rd_en && !pready_o) ? rd_mux : 32'h00000000;
         timer1_reset_o <= special;
         adc_start_o    <= special & tb_i.adc_enabled;
         port_pin_zero_o     <= unit_io_pin_out;
         port_pin_zero_oe_o  <= drive & pin_route_select;
         port_pin_three_o    <= unit_io_pin_out;
         port_pin_three_oe_o <= drive & ~pin_route_select;
         irq_o <= |(nxt_status & mask_ff);
      end
   end

   // ************************************************************************
   // Assertions
   // ************************************************************************
   sequence s_special;
      special;
   endsequence
   a_special_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      s_special |=> timer1_reset_o) else $error("timer1 reset missing");
   a_adc_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      adc_start_o |-> $past(tb_i.adc_enabled) && timer1_reset_o)
      else $error("adc start without enable");
   a_route_excl: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !(port_pin_zero_oe_o && port_pin_three_oe_o)) else $error("both pins driven");
   a_route_sel: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      port_pin_zero_oe_o |-> $past(pin_route_select)) else $error("wrong pin route");
   a_capture_latch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      capture_ev |=> value_ff == $past(tb_i.timer1)) else $error("capture lost");
   a_low_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (wr_en && sel_lo && !capture_ev) |=> value_ff[7:0] == $past(pwdata_i[7:0])
      && $stable(value_ff[15:8])) else $error("low byte write bad");
   a_cmp_timer1: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      cmp_ev_ff |-> $past(tb_i.timer1) == $past(value_ff)) else $error("compare base");
   a_off_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      mode_off [*2] |-> !port_pin_zero_oe_o && !port_pin_three_oe_o)
      else $error("disabled unit drives");
endmodule
`default_nettype wire

// file: ccp_pkg.sv
// Package of constants and carrier types for the capture/compare/PWM unit
// ****************************************************************************
// Summary of operation
// - One 16-bit value register serves as capture latch, compare value or PWM duty register.
// - The value register is reached as two 8-bit registers, a low byte and a high byte.
// - A special-event compare match resets Timer1 and starts a conversion if the converter is on.
// - The unit's pin is routed to port pin zero or three by configuration bit 12.
// - Capture and compare use Timer1 as time base; PWM uses Timer2.
// ****************************************************************************
`default_nettype none
package ccp_pkg;
   // Register byte addresses (index times four)
   localparam logic [7:0]  CTRL_IDX     = 8'h17;
   localparam logic [11:0] ADDR_CTRL    = 12'h05C;
   localparam logic [11:0] ADDR_VAL_LO  = 12'h100;
   localparam logic [11:0] ADDR_VAL_HI  = 12'h104;
   localparam logic [11:0] ADDR_STATUS  = 12'h108;
   localparam logic [11:0] ADDR_MASK    = 12'h10C;
   localparam logic [11:0] ADDR_CONFIG  = 12'h110;
   // Control and configuration field positions
   localparam int MODE_LSB   = 0;
   localparam int DUTY_Y_POS = 4;
   localparam int DUTY_X_POS = 5;
   localparam int ROUTE_BIT  = 12;
   // Reset values
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   // Status bit positions
   localparam int ST_CAPTURE = 0;
   localparam int ST_COMPARE = 1;
   localparam int ST_PWM     = 2;
   // Mode codes
   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_CAP_F   = 4'h4;
   localparam logic [3:0] MODE_CAP_R   = 4'h5;
   localparam logic [3:0] MODE_CAP_R4  = 4'h6;
   localparam logic [3:0] MODE_CAP_R16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SW  = 4'hA;
   localparam logic [3:0] MODE_CMP_SPC = 4'hB;
   // Timer base signals from the surrounding timers
   typedef struct packed
   {
      logic [15:0] timer1;
      logic [7:0]  timer2;
      logic        timer2_period;
      logic        adc_enabled;
   } timebase_t;
endpackage
`default_nettype wire

// file: ccp_capture_unit.sv
// Capture edge detector and prescaler
`timescale 1ns/1ps
`default_nettype none
module ccp_capture_unit
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Control
   input  wire logic [3:0] mode_i,
   input  wire logic       pin_i,
   // Event
   output logic            capture_o
);
   logic       pin_ff;
   logic [3:0] pre_ff;
   logic [3:0] nxt_pre;
   wire        rise  = pin_i & ~pin_ff;
   wire        fall  = ~pin_i & pin_ff;
   wire        is_cap = (mode_i[3:2] == 2'b01);
   wire        edge_ok = (mode_i == ccp_pkg::MODE_CAP_F) ? fall : rise;
   wire [3:0]  limit = (mode_i == ccp_pkg::MODE_CAP_R4) ? 4'h3 :
                       (mode_i == ccp_pkg::MODE_CAP_R16) ? 4'hF : 4'h0;
   wire        hit = is_cap & edge_ok & (pre_ff == limit);
   // Prescaler counts qualifying edges; it restarts whenever capture is off
   assign nxt_pre = !is_cap ? 4'h0 : (is_cap & edge_ok) ? (hit ? 4'h0 : pre_ff + 4'h1) : pre_ff;
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pin_ff    <= 1'b0;
         pre_ff    <= 4'h0;
         capture_o <= 1'b0;
      end
      else
      begin
         pin_ff    <= pin_i;
         pre_ff    <= nxt_pre;
         capture_o <= hit;
      end
   end
endmodule
`default_nettype wire

// file: ccp_pwm_unit.sv
// Ten-bit PWM generator on the Timer2 time base
`timescale 1ns/1ps
`default_nettype none
module ccp_pwm_unit
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   // Control
   input  wire logic       enable_i,
   input  wire logic [9:0] duty_i,
   input  wire logic [7:0] timer2_i,
   input  wire logic       period_i,
   // Output
   output logic            pwm_o,
   output logic            period_o
);
   logic [9:0] latch_ff;
   logic [9:0] sub_ff;
   // Duty is latched at the period boundary so a mid-period write cannot glitch
   wire [9:0] count = {timer2_i, sub_ff[1:0]};
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latch_ff <= 10'h000;
         sub_ff   <= 10'h000;
         pwm_o    <= 1'b0;
         period_o <= 1'b0;
      end
      else
      begin
         sub_ff   <= (!enable_i || period_i) ? 10'h000 : sub_ff + 10'h001;
         period_o <= enable_i & period_i;
         if (!enable_i)
         begin
            pwm_o <= 1'b0;
         end
         else if (period_i)
         begin
            latch_ff <= duty_i;
            pwm_o    <= (duty_i != 10'h000);
         end
         else if (count >= latch_ff)
         begin
            pwm_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: ccp_timer_model.sv
// Timer1, Timer2 and converter-enable model standing beside the unit
`timescale 1ns/1ps
`default_nettype none
module ccp_timer_model
#(
   parameter logic [7:0] PERIOD = 8'h0F
)
(
   // Clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          reset_i,
   // Bench control
   input  wire logic          run_i,
   input  wire logic          load_i,
   input  wire logic [15:0]   load_val_i,
   input  wire logic          adc_on_i,
   // Unit side
   input  wire logic          timer1_reset_i,
   output var ccp_pkg::timebase_t tb_o
);
   logic [15:0] t1_ff;
   logic [7:0]  t2_ff;
   logic [1:0]  pre_ff;
   // Timer2 steps once per four clocks; Timer1 may be frozen to pin a capture value
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         t1_ff  <= 16'h0000;
         t2_ff  <= 8'h00;
         pre_ff <= 2'h0;
      end
      else
      begin
         pre_ff <= pre_ff + 2'h1;
         if (pre_ff == 2'h3)
            t2_ff <= (t2_ff == PERIOD) ? 8'h00 : t2_ff + 8'h01;
         if (load_i)
            t1_ff <= load_val_i;
         else if (timer1_reset_i)
            t1_ff <= 16'h0000; // Obeys the special event
         else if (run_i)
            t1_ff <= t1_ff + 16'h0001;
      end
   end
   // Period pulse lasts one clock, as Timer2 wraps
   assign tb_o = '{timer1: t1_ff, timer2: t2_ff, adc_enabled: adc_on_i,
                   timer2_period: (pre_ff == 2'h3) && (t2_ff == PERIOD)};
endmodule
`default_nettype wire

// file: test_capture_compare_pwm_unit.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
module test_capture_compare_pwm_unit;
   logic        ref_clk_i, reset_i, psel, penable, pwrite, pready, pslverr, slv;
   logic        t1_run, t1_load, adc_on, t1_rst, adc_go, irq;
   logic        z_o, z_oe, t_o, t_oe, z_drv, t_drv;
   logic [11:0] paddr;
   logic [15:0] t1_val;
   logic [31:0] pwdata, prdata, rd;
   int          err_total, checks, cyc, n_rst, n_adc, hi, r0, a0;
   ccp_pkg::timebase_t tb;
   // Pin level: the unit when it drives, the bench otherwise
   wire logic   z_pin = z_oe ? z_o : z_drv;
   wire logic   t_pin = t_oe ? t_o : t_drv;
   ccp_timer_model #(.PERIOD(8'h0F)) timers
   (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .run_i(t1_run), .load_i(t1_load),
    .load_val_i(t1_val), .adc_on_i(adc_on), .timer1_reset_i(t1_rst), .tb_o(tb));
   ccp_top dut
   (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tb_i(tb), .timer1_reset_o(t1_rst),
    .adc_start_o(adc_go), .port_pin_zero_i(z_pin), .port_pin_zero_o(z_o),
    .port_pin_zero_oe_o(z_oe), .port_pin_three_i(t_pin), .port_pin_three_o(t_o),
    .port_pin_three_oe_o(t_oe), .irq_o(irq));
   // 50 MHz clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // Event pulse counts and hang guard
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      n_rst <= n_rst + int'(t1_rst === 1'b1);
      n_adc <= n_adc + int'(adc_go === 1'b1);
      if (cyc == 30000)
      begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // APB transfer; waits up to 20 clocks for pready, counting an error if it never comes
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk_i);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      err_total += int'(n == 20);
      rd = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic t1_set(input logic [15:0] v);
      @(posedge ref_clk_i);
      t1_load <= 1'b1;
      t1_val  <= v;
      @(posedge ref_clk_i);
      t1_load <= 1'b0;
   endtask
   // Drives one pin, then lets three clocks pass for the edge detector
   task automatic pin(input int r, input logic v);
      if (r == 1)
         z_drv <= v;
      else
         t_drv <= v;
      repeat (3) @(posedge ref_clk_i);
   endtask
   task automatic t_reset();
      rdchk(ccp_pkg::ADDR_CTRL, 32'h0);
      rdchk(ccp_pkg::ADDR_VAL_HI, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk(32'(slv), 32'h1);
      chk(32'(irq), 32'h0);
   endtask
   task automatic t_regs();
      wr(ccp_pkg::ADDR_VAL_LO, 32'hA5);
      wr(ccp_pkg::ADDR_VAL_HI, 32'h3C);
      rdchk(ccp_pkg::ADDR_VAL_LO, 32'hA5);
      rdchk(ccp_pkg::ADDR_VAL_HI, 32'h3C);
      wr(ccp_pkg::ADDR_CTRL, 32'hFF);
      rdchk(ccp_pkg::ADDR_CTRL, 32'h3F);
   endtask
   // Falling capture on pin three, rising on pin zero; the other pin must be ignored
   task automatic t_capture();
      for (int r = 0; r < 2; r++)
      begin
         wr(ccp_pkg::ADDR_CONFIG, r ? 32'h1000 : 32'h0);
         wr(ccp_pkg::ADDR_CTRL, r ? ccp_pkg::MODE_CAP_R : ccp_pkg::MODE_CAP_F);
         wr(ccp_pkg::ADDR_STATUS, 32'h7);
         t1_set(16'hC3C3);
         pin(1 - r, 1'b1);
         pin(1 - r, 1'b0);
         t1_set(16'hA1A1);
         pin(r, 1'b1);
         t1_set(16'hB2B2);
         pin(r, 1'b0);
         rdchk(ccp_pkg::ADDR_VAL_LO, r ? 32'hA1 : 32'hB2);
         rdchk(ccp_pkg::ADDR_VAL_HI, r ? 32'hA1 : 32'hB2);
      end
      // Every fourth rise on pin zero: only the fourth edge latches Timer1
      wr(ccp_pkg::ADDR_CTRL, ccp_pkg::MODE_CAP_R4);
      for (int i = 0; i < 4; i++)
      begin
         t1_set(16'h0100 + 16'(i));
         pin(1, 1'b1);
         pin(1, 1'b0);
      end
      rdchk(ccp_pkg::ADDR_VAL_LO, 32'h03);
      rdchk(ccp_pkg::ADDR_VAL_HI, 32'h01);
      rdchk(ccp_pkg::ADDR_STATUS, 32'h1);
      chk(32'(irq), 32'h0);
      wr(ccp_pkg::ADDR_MASK, 32'h7);
      repeat (2) @(posedge ref_clk_i);
      chk(32'(irq), 32'h1);
      wr(ccp_pkg::ADDR_STATUS, 32'h7);
      rdchk(ccp_pkg::ADDR_STATUS, 32'h0);
      chk(32'(irq), 32'h0);
   endtask
   // Set then clear on match with Timer1 running past the value
   task automatic t_compare();
      wr(ccp_pkg::ADDR_VAL_LO, 32'h40);
      wr(ccp_pkg::ADDR_VAL_HI, 32'h0);
      for (int c = 0; c < 2; c++)
      begin
         wr(ccp_pkg::ADDR_CTRL, c ? ccp_pkg::MODE_CMP_CLR : ccp_pkg::MODE_CMP_SET);
         wr(ccp_pkg::ADDR_STATUS, 32'h7);
         t1_set(16'h0030);
         t1_run <= 1'b1;
         rdchk(ccp_pkg::ADDR_STATUS, 32'h0);
         repeat (40) @(posedge ref_clk_i);
         t1_run <= 1'b0;
         rdchk(ccp_pkg::ADDR_STATUS, 32'h2);
         chk({30'h0, z_oe, z_o}, c ? 32'h2 : 32'h3);
         chk(32'(t_oe), 32'h0);
      end
   endtask
   // Special event with the converter on, then off
   task automatic t_special();
      wr(ccp_pkg::ADDR_VAL_LO, 32'h50);
      wr(ccp_pkg::ADDR_CTRL, ccp_pkg::MODE_CMP_SPC);
      for (int e = 1; e >= 0; e--)
      begin
         adc_on <= e[0];
         t1_set(16'h0040);
         r0 = n_rst;
         a0 = n_adc;
         t1_run <= 1'b1;
         repeat (60) @(posedge ref_clk_i);
         chk(n_rst - r0, 32'h1);
         chk(n_adc - a0, e);
         chk(32'(tb.timer1 < 16'h0050), 32'h1);
      end
      t1_run <= 1'b0;
   endtask
   // Two PWM codes and duties on pin three, Timer1 frozen
   task automatic t_pwm();
      wr(ccp_pkg::ADDR_CONFIG, 32'h0);
      for (int p = 0; p < 2; p++)
      begin
         wr(ccp_pkg::ADDR_VAL_LO, p ? 32'h09 : 32'h05);
         wr(ccp_pkg::ADDR_CTRL, p ? 32'h1F : 32'h2C);
         repeat (128) @(posedge ref_clk_i);
         hi = 0;
         repeat (64)
         begin
            @(posedge ref_clk_i);
            hi += int'(t_o === 1'b1);
         end
         chk(32'(hi >= (p ? 33 : 18) && hi <= (p ? 41 : 26)), 32'h1);
         chk({30'h0, t_oe, z_oe}, 32'h2);
      end
      wr(ccp_pkg::ADDR_CTRL, ccp_pkg::MODE_OFF);
      repeat (2) @(posedge ref_clk_i);
      chk(32'(t_oe), 32'h0);
   endtask
   task automatic end_of_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence: reset for four clocks, then each scenario
   initial
   begin
      {reset_i, psel, penable, pwrite, t1_run, t1_load, adc_on, z_drv, t_drv} = 9'h100;
      {paddr, pwdata, t1_val} = 60'h0;
      {err_total, checks, cyc, n_rst, n_adc} = 160'h0;
      repeat (4) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_regs();
      t_capture();
      t_compare();
      t_special();
      t_pwm();
      end_of_test();
   end
endmodule
`default_nettype wire
